// ==== hw/pfs_pkg.sv ====
// constants, field layouts and carrier types of the pad function select block
package pfs_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] PAD_A_CFG_ADDR  = 32'h4402_E0C0;  // pad_eight_function_config
  localparam logic [31:0] PAD_B_CFG_ADDR  = 32'h4402_E0C4;  // pad_nine_function_config
  localparam logic [31:0] PAD_AUX_ADDR    = 32'h4402_E0C8;  // switch, strap level, path
  localparam logic [31:0] PAD_STATUS_ADDR = 32'h4402_E0CC;  // read-only pad status

  // ==========================================================
  // mode values of the pad configuration registers
  localparam logic [3:0] MODE_GPIO    = 4'h0;
  localparam logic [3:0] MODE_PWM     = 4'h3;
  localparam logic [3:0] MODE_CARD    = 4'h6;
  localparam logic [3:0] MODE_AUDIO   = 4'h7;
  localparam logic [3:0] MODE_CAPTURE = 4'hC;

  // ==========================================================
  // field positions
  localparam int CFG_MODE_LSB     = 0;
  localparam int CFG_OBUF_DIS_BIT = 4;
  localparam int CFG_PULL_EN_BIT  = 8;
  localparam int CFG_PULL_UP_BIT  = 9;
  localparam int AUX_ADC_SW_BIT   = 0;
  localparam int AUX_STRAP_BIT    = 1;
  localparam int AUX_DIG_PATH_BIT = 2;
  localparam int STS_PAD_A_BIT    = 0;
  localparam int STS_PAD_B_BIT    = 1;
  localparam int STS_SLEEP_BIT    = 2;
  localparam int STS_HIB_BIT      = 3;
  localparam int STS_PIN_RST_BIT  = 4;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic       pull_up;   // pull direction, 1 up
    logic       pull_en;   // software pull enable, marks pad in use
    logic       obuf_dis;  // force output buffer off
    logic [3:0] mode;      // function select
  } pfs_pad_cfg_s;

  typedef struct packed {
    logic o;     // pad output level
    logic oe_n;  // output enable, low drives
    logic pu;    // pullup enable
    logic pd;    // pulldown enable
  } pfs_pad_drv_s;

  typedef struct packed {
    logic gpio_a;    // general_pad_a input
    logic card_irq;  // card_interrupt_in
    logic cap_six;   // timer_capture_six
    logic gpio_b;    // general_pad_b input
    logic card_dat;  // card_data_line input
    logic aud_dat;   // audio_data_line input
    logic cap_zero;  // timer_capture_zero
  } pfs_periph_in_s;

  typedef struct packed {
    pfs_pad_cfg_s   cfg_a;
    pfs_pad_cfg_s   cfg_b;
    logic           adc_sw;
    logic           strap_lvl;
    logic           dig_path;
    logic [2:0]     sync1;     // first stage {chip_reset_low, pad b, pad a}
    logic [2:0]     sync2;     // second stage
    pfs_pad_drv_s   drv_a;
    pfs_pad_drv_s   drv_b;
    pfs_pad_drv_s   drv_s;
    pfs_periph_in_s per_in;
    logic [31:0]    rdata;
    logic           slverr;
  } pfs_state_s;

  // ==========================================================
  // values after reset
  localparam pfs_pad_cfg_s PAD_CFG_RST   = 7'h00;
  localparam logic         ADC_SW_RST    = 1'b0;
  localparam logic         STRAP_LVL_RST = 1'b1;
  localparam logic         DIG_PATH_RST  = 1'b0;
  localparam pfs_pad_drv_s DRV_HIZ       = 4'h4;   // oe_n high, no pulls
  localparam pfs_pad_drv_s DRV_STRAP_RST = 4'h8;   // driven high, oe_n low

endpackage : pfs_pkg

// ==== hw/pfs_top.sv ====
// pad function select and low-power pad state logic for two pads and the strap pad
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module pfs_top (
  input  wire logic                   CORE_CLK,         // 125 MHz clock
  input  wire logic                   RST,              // synchronous reset, high
  input  wire logic [31:0]            PADDR,            // apb address
  input  wire logic                   PSEL,             // apb select
  input  wire logic                   PENABLE,          // apb access phase
  input  wire logic                   PWRITE,           // apb direction
  input  wire logic [31:0]            PWDATA,           // apb write data
  output logic                        PREADY,           // apb ready
  output logic [31:0]                 PRDATA,           // apb read data
  output logic                        PSLVERR,          // apb error
  input  wire logic                   DEEP_SLEEP,       // deep_sleep_state level
  input  wire logic                   HIBERNATE,        // hibernate level
  input  wire logic                   ROM_BOOT_DONE,    // boot code pulse
  input  wire logic                   CHIP_RESET_LOW_N, // chip_reset_low pin
  input  wire logic                   PAD_A_I,          // general_pad_a level in
  output pfs_pkg::pfs_pad_drv_s       PAD_A_DRV,        // general_pad_a drive
  input  wire logic                   PAD_B_I,          // general_pad_b level in
  output pfs_pkg::pfs_pad_drv_s       PAD_B_DRV,        // general_pad_b drive
  output pfs_pkg::pfs_pad_drv_s       STRAP_DRV,        // boot_mode_strap_two drive
  output logic                        ADC_SWITCH_EN,    // analog pass switch
  input  wire logic                   GPIO_A_OUT,       // gpio level for pad A
  input  wire logic                   GPIO_A_OE,        // gpio enable for pad A
  input  wire logic                   FRAME_SYNC_OUT,   // audio_frame_sync
  input  wire logic                   GPIO_B_OUT,       // gpio level for pad B
  input  wire logic                   GPIO_B_OE,        // gpio enable for pad B
  input  wire logic                   PWM_FIVE_OUT,     // timer_pulse_out_five
  input  wire logic                   CARD_DATA_OUT,    // card_data_line out
  input  wire logic                   CARD_DATA_OE,     // card_data_line enable
  input  wire logic                   AUDIO_DATA_OUT,   // audio_data_line out
  input  wire logic                   AUDIO_DATA_OE,    // audio_data_line enable
  output pfs_pkg::pfs_periph_in_s     PERIPH_IN         // routed pad inputs
);

  pfs_pkg::pfs_state_s s_r;
  pfs_pkg::pfs_state_s s_nxt;

  // ==========================================================
  // helpers
  // final pad drive from function drive, config and power state
  function automatic pfs_pkg::pfs_pad_drv_s pad_state(
    input logic                  o,
    input logic                  oe,
    input pfs_pkg::pfs_pad_cfg_s c,
    input logic                  sleep,
    input logic                  hib,
    input logic                  off
  );
    pfs_pkg::pfs_pad_drv_s d;
    d = pfs_pkg::DRV_HIZ;
    if (hib || off) begin
      d = pfs_pkg::DRV_HIZ;
    end else if (sleep) begin
      d.oe_n = 1'b1;
      d.pu   = c.pull_en & c.pull_up;
      d.pd   = c.pull_en ? ~c.pull_up : 1'b1;
    end else begin
      d.o    = o;
      d.oe_n = ~(oe & ~c.obuf_dis);
      d.pu   = c.pull_en & c.pull_up;
      d.pd   = c.pull_en & ~c.pull_up;
    end
    return d;
  endfunction : pad_state

  // register readback
  function automatic logic [31:0] reg_read(input logic [31:0] a, input pfs_pkg::pfs_state_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == pfs_pkg::PAD_A_CFG_ADDR) begin
      v[pfs_pkg::CFG_MODE_LSB +: 4]  = s.cfg_a.mode;
      v[pfs_pkg::CFG_OBUF_DIS_BIT]   = s.cfg_a.obuf_dis;
      v[pfs_pkg::CFG_PULL_EN_BIT]    = s.cfg_a.pull_en;
      v[pfs_pkg::CFG_PULL_UP_BIT]    = s.cfg_a.pull_up;
    end else if (a == pfs_pkg::PAD_B_CFG_ADDR) begin
      v[pfs_pkg::CFG_MODE_LSB +: 4]  = s.cfg_b.mode;
      v[pfs_pkg::CFG_OBUF_DIS_BIT]   = s.cfg_b.obuf_dis;
      v[pfs_pkg::CFG_PULL_EN_BIT]    = s.cfg_b.pull_en;
      v[pfs_pkg::CFG_PULL_UP_BIT]    = s.cfg_b.pull_up;
    end else if (a == pfs_pkg::PAD_AUX_ADDR) begin
      v[pfs_pkg::AUX_ADC_SW_BIT]     = s.adc_sw;
      v[pfs_pkg::AUX_STRAP_BIT]      = s.strap_lvl;
      v[pfs_pkg::AUX_DIG_PATH_BIT]   = s.dig_path;
    end else if (a == pfs_pkg::PAD_STATUS_ADDR) begin
      v[pfs_pkg::STS_PAD_A_BIT]      = s.sync2[0];
      v[pfs_pkg::STS_PAD_B_BIT]      = s.sync2[1];
      v[pfs_pkg::STS_SLEEP_BIT]      = DEEP_SLEEP;
      v[pfs_pkg::STS_HIB_BIT]        = HIBERNATE;
      v[pfs_pkg::STS_PIN_RST_BIT]    = ~s.sync2[2];
    end else begin
      v = 32'h0000_0000;
    end
    return v;
  endfunction : reg_read

  // address map membership
  function automatic logic reg_hit(input logic [31:0] a);
    return (a == pfs_pkg::PAD_A_CFG_ADDR) || (a == pfs_pkg::PAD_B_CFG_ADDR) ||
           (a == pfs_pkg::PAD_AUX_ADDR) || (a == pfs_pkg::PAD_STATUS_ADDR);
  endfunction : reg_hit

  // config fields from a write word
  function automatic pfs_pkg::pfs_pad_cfg_s cfg_from(input logic [31:0] w);
    pfs_pkg::pfs_pad_cfg_s c;
    c.mode     = w[pfs_pkg::CFG_MODE_LSB +: 4];
    c.obuf_dis = w[pfs_pkg::CFG_OBUF_DIS_BIT];
    c.pull_en  = w[pfs_pkg::CFG_PULL_EN_BIT];
    c.pull_up  = w[pfs_pkg::CFG_PULL_UP_BIT];
    return c;
  endfunction : cfg_from

  // ==========================================================
  // next-state logic
  always_comb begin
    logic                   pad_a;
    logic                   pad_b;
    logic                   off;
    logic                   o_a;
    logic                   oe_a;
    logic                   o_b;
    logic                   oe_b;
    pfs_pkg::pfs_periph_in_s pin;
    pad_a = s_r.sync2[0];
    pad_b = s_r.sync2[1];
    off   = ~s_r.sync2[2] | ~s_r.dig_path;
    o_a   = 1'b0;
    oe_a  = 1'b0;
    o_b   = 1'b0;
    oe_b  = 1'b0;
    pin   = '0;
    s_nxt = s_r;
    // pin synchronisers
    s_nxt.sync1 = {CHIP_RESET_LOW_N, PAD_B_I, PAD_A_I};
    s_nxt.sync2 = s_r.sync1;
    // pad A function routing, reserved modes connect nothing
    case (s_r.cfg_a.mode)
      pfs_pkg::MODE_GPIO: begin
        o_a        = GPIO_A_OUT;
        oe_a       = GPIO_A_OE;
        pin.gpio_a = pad_a;
      end
      pfs_pkg::MODE_CARD:    pin.card_irq = pad_a;
      pfs_pkg::MODE_AUDIO: begin
        o_a  = FRAME_SYNC_OUT;
        oe_a = 1'b1;
      end
      pfs_pkg::MODE_CAPTURE: pin.cap_six = pad_a;
      default: oe_a = 1'b0;
    endcase
    // pad B function routing
    case (s_r.cfg_b.mode)
      pfs_pkg::MODE_GPIO: begin
        o_b        = GPIO_B_OUT;
        oe_b       = GPIO_B_OE;
        pin.gpio_b = pad_b;
      end
      pfs_pkg::MODE_PWM: begin
        o_b  = PWM_FIVE_OUT;
        oe_b = 1'b1;
      end
      pfs_pkg::MODE_CARD: begin
        o_b          = CARD_DATA_OUT;
        oe_b         = CARD_DATA_OE;
        pin.card_dat = pad_b;
      end
      pfs_pkg::MODE_AUDIO: begin
        o_b         = AUDIO_DATA_OUT;
        oe_b        = AUDIO_DATA_OE;
        pin.aud_dat = pad_b;
      end
      pfs_pkg::MODE_CAPTURE: pin.cap_zero = pad_b;
      default: oe_b = 1'b0;
    endcase
    s_nxt.per_in = off ? '0 : pin;
    s_nxt.drv_a  = pad_state(o_a, oe_a, s_r.cfg_a, DEEP_SLEEP, HIBERNATE, off);
    s_nxt.drv_b  = pad_state(o_b, oe_b, s_r.cfg_b, DEEP_SLEEP, HIBERNATE, off);
    // strap pad is output only; hibernate leaves it floating on a pulldown
    if (HIBERNATE) begin
      s_nxt.drv_s = pfs_pkg::DRV_HIZ;
      s_nxt.drv_s.pd = 1'b1;
    end else begin
      s_nxt.drv_s = pfs_pkg::DRV_STRAP_RST;
      s_nxt.drv_s.o = s_r.strap_lvl;
    end
    // boot code opens the digital path
    if (ROM_BOOT_DONE) begin
      s_nxt.dig_path = 1'b1;
    end
    // apb setup phase prepares read data and error
    if (PSEL && !PENABLE) begin
      s_nxt.rdata  = reg_read(PADDR, s_r);
      s_nxt.slverr = ~reg_hit(PADDR);
    end
    // apb access phase commits writes
    if (PSEL && PENABLE && PWRITE) begin
      if (PADDR == pfs_pkg::PAD_A_CFG_ADDR) begin
        s_nxt.cfg_a = cfg_from(PWDATA);
      end else if (PADDR == pfs_pkg::PAD_B_CFG_ADDR) begin
        s_nxt.cfg_b = cfg_from(PWDATA);
      end else if (PADDR == pfs_pkg::PAD_AUX_ADDR) begin
        s_nxt.adc_sw    = PWDATA[pfs_pkg::AUX_ADC_SW_BIT];
        s_nxt.strap_lvl = PWDATA[pfs_pkg::AUX_STRAP_BIT];
        s_nxt.dig_path  = PWDATA[pfs_pkg::AUX_DIG_PATH_BIT] | ROM_BOOT_DONE;
      end
    end
    // synchronous reset
    if (RST) begin
      s_nxt           = '0;
      s_nxt.cfg_a     = pfs_pkg::PAD_CFG_RST;
      s_nxt.cfg_b     = pfs_pkg::PAD_CFG_RST;
      s_nxt.adc_sw    = pfs_pkg::ADC_SW_RST;
      s_nxt.strap_lvl = pfs_pkg::STRAP_LVL_RST;
      s_nxt.dig_path  = pfs_pkg::DIG_PATH_RST;
      s_nxt.drv_a     = pfs_pkg::DRV_HIZ;
      s_nxt.drv_b     = pfs_pkg::DRV_HIZ;
      s_nxt.drv_s     = pfs_pkg::DRV_STRAP_RST;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CORE_CLK) begin
    s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  assign PREADY        = 1'b1;
  assign PRDATA        = s_r.rdata;
  assign PSLVERR       = s_r.slverr;
  assign PAD_A_DRV     = s_r.drv_a;
  assign PAD_B_DRV     = s_r.drv_b;
  assign STRAP_DRV     = s_r.drv_s;
  assign ADC_SWITCH_EN = s_r.adc_sw;
  assign PERIPH_IN     = s_r.per_in;

endmodule : pfs_top

// ==== testbench/pfs_monitor.sv ====
// assertion checker for the pad function select block
`timescale 1ns/100ps
module pfs_monitor (
  input wire logic                  CORE_CLK,         // clock
  input wire logic                  RST,              // sync reset
  input wire logic [31:0]           PADDR,            // apb address
  input wire logic                  PSEL,             // apb select
  input wire logic                  PENABLE,          // apb access
  input wire logic                  PWRITE,           // apb write
  input wire logic [31:0]           PWDATA,           // apb data
  input wire logic                  DEEP_SLEEP,       // sleep level
  input wire logic                  HIBERNATE,        // hibernate level
  input wire logic                  ROM_BOOT_DONE,    // boot pulse
  input wire logic                  CHIP_RESET_LOW_N, // reset pin
  input wire logic                  FRAME_SYNC_OUT,   // frame sync source
  input wire logic                  PWM_FIVE_OUT,     // pwm source
  input wire logic                  ADC_SWITCH_EN,    // pass switch
  input wire pfs_pkg::pfs_pad_drv_s PAD_A_DRV,        // pad a drive
  input wire pfs_pkg::pfs_pad_drv_s PAD_B_DRV,        // pad b drive
  input wire pfs_pkg::pfs_pad_drv_s STRAP_DRV         // strap drive
);
  // ==========
  // shadow of pad configuration and power path
  logic [9:0] ca_r, cb_r;
  logic [2:0] ph_r;
  logic       dig_r, wr, live, norm;
  assign wr   = PSEL && PENABLE && PWRITE;
  assign live = dig_r && CHIP_RESET_LOW_N && &ph_r;
  assign norm = live && !DEEP_SLEEP && !HIBERNATE;
  always_ff @(posedge CORE_CLK) begin
    ph_r <= RST ? 3'h0 : {ph_r[1:0], CHIP_RESET_LOW_N};
    if (RST) begin
      ca_r  <= 10'h000;
      cb_r  <= 10'h000;
      dig_r <= 1'b0;
    end else begin
      if (wr && PADDR == pfs_pkg::PAD_A_CFG_ADDR) ca_r <= PWDATA[9:0];
      if (wr && PADDR == pfs_pkg::PAD_B_CFG_ADDR) cb_r <= PWDATA[9:0];
      if (ROM_BOOT_DONE) dig_r <= 1'b1;
      else if (wr && PADDR == pfs_pkg::PAD_AUX_ADDR) dig_r <= PWDATA[2];
    end
  end
  // ==========
  // properties
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_hib_pads_hiz: assert property (HIBERNATE |=>
    PAD_A_DRV[2:0] == 3'h4 && PAD_B_DRV[2:0] == 3'h4) else $error("pad live in hibernate");
  a_hib_strap_pd: assert property (HIBERNATE |=>
    STRAP_DRV[2:0] == 3'h5) else $error("strap not pulled down");
  a_strap_out_only: assert property (!HIBERNATE |=>
    !STRAP_DRV.oe_n) else $error("strap not driven");
  a_sleep_unused_pd: assert property (DEEP_SLEEP && !HIBERNATE && live && !ca_r[8] |=>
    PAD_A_DRV[2:0] == 3'h5) else $error("unused pad not pulled down");
  a_sleep_used_pull: assert property (DEEP_SLEEP && !HIBERNATE && live && ca_r[8] |=>
    PAD_A_DRV[2:0] == {1'b1, $past(ca_r[9]), !$past(ca_r[9])}) else $error("sleep pull wrong");
  a_sync_route: assert property (norm && ca_r[4:0] == 5'h07 |=>
    PAD_A_DRV[3:2] == {$past(FRAME_SYNC_OUT), 1'b0}) else $error("frame sync not routed");
  a_pwm_route: assert property (norm && cb_r[4:0] == 5'h03 |=>
    PAD_B_DRV[3:2] == {$past(PWM_FIVE_OUT), 1'b0}) else $error("pwm not routed");
  a_input_mode_undriven: assert property (!(ca_r[3:0] inside {4'h0, 4'h7}) |=>
    PAD_A_DRV.oe_n) else $error("pad driven in input or reserved mode");
  a_switch_reset_off: assert property ($fell(RST) |->
    !ADC_SWITCH_EN) else $error("switch closed after reset");
endmodule : pfs_monitor

bind pfs_top pfs_monitor u_pfs_monitor (.CORE_CLK(CORE_CLK), .RST(RST), .PADDR(PADDR),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
  .DEEP_SLEEP(DEEP_SLEEP), .HIBERNATE(HIBERNATE), .ROM_BOOT_DONE(ROM_BOOT_DONE),
  .CHIP_RESET_LOW_N(CHIP_RESET_LOW_N), .FRAME_SYNC_OUT(FRAME_SYNC_OUT),
  .PWM_FIVE_OUT(PWM_FIVE_OUT), .ADC_SWITCH_EN(ADC_SWITCH_EN),
  .PAD_A_DRV(PAD_A_DRV), .PAD_B_DRV(PAD_B_DRV), .STRAP_DRV(STRAP_DRV));

// ==== testbench/pfs_pad_env.sv ====
// far-side pad model: outside source, pulls and an undriven line
`timescale 1ns/100ps
module pfs_pad_env (
  input wire logic                  clk,     // bench clock
  input wire pfs_pkg::pfs_pad_drv_s drv,     // drive from the block
  input wire logic                  ext_en,  // far side drives
  input wire logic                  ext_val, // far side level
  output logic                      pad      // resolved level
);
  // ==========
  // block first, then far side, then pulls, else a toggling line
  logic flip = 1'b0;
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    if (!drv.oe_n) pad = drv.o;
    else if (ext_en) pad = ext_val;
    else if (drv.pu || drv.pd) pad = drv.pu;
    else pad = flip;
  end
  // no far-side source is ever put on the strap pad
  // output-only pads, like the strap pad, get no far-side source
endmodule : pfs_pad_env

// ==== testbench/pfs_top_test.sv ====
// self-checking bench of the pad function select block
`timescale 1ns/100ps
module pfs_top_test;
  // ==========
  // stimulus, model state and counters
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, slv;
  logic        slp = 1'b0, hib = 1'b0, boot = 1'b0, pin = 1'b1, adc, pa, pb, er;
  logic [31:0] paddr = '0, pwd = '0, prd, rd, v;
  logic [9:0]  po = '0;
  logic [1:0]  xe = '0, xv = '0;
  logic [3:0]  ea, eb;
  pfs_pkg::pfs_pad_drv_s   da, db, ds;
  pfs_pkg::pfs_periph_in_s pi;
  int n_fail = 0, n_tests = 0, seed = 56, aux = 2, msk, cfg[2], ml[6] = '{0, 3, 6, 7, 12, 5};
  always #4 clk = ~clk;
  pfs_top u_pfs_top (.CORE_CLK(clk), .RST(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PWDATA(pwd), .PREADY(rdy), .PRDATA(prd), .PSLVERR(slv),
    .DEEP_SLEEP(slp), .HIBERNATE(hib), .ROM_BOOT_DONE(boot), .CHIP_RESET_LOW_N(pin),
    .PAD_A_I(pa), .PAD_A_DRV(da), .PAD_B_I(pb), .PAD_B_DRV(db), .STRAP_DRV(ds),
    .ADC_SWITCH_EN(adc), .GPIO_A_OUT(po[0]), .GPIO_A_OE(po[1]), .FRAME_SYNC_OUT(po[2]),
    .GPIO_B_OUT(po[3]), .GPIO_B_OE(po[4]), .PWM_FIVE_OUT(po[5]), .CARD_DATA_OUT(po[6]),
    .CARD_DATA_OE(po[7]), .AUDIO_DATA_OUT(po[8]), .AUDIO_DATA_OE(po[9]), .PERIPH_IN(pi));
  pfs_pad_env u_pfs_pad_env_a (.clk(clk), .drv(da), .ext_en(xe[0]), .ext_val(xv[0]), .pad(pa));
  pfs_pad_env u_pfs_pad_env_b (.clk(clk), .drv(db), .ext_en(xe[1]), .ext_val(xv[1]), .pad(pb));
  // ==========
  // compare, verdict and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_pad(input logic [3:0] g, input logic [3:0] e);
    logic [3:0] m;
    m = !e[2] ? 4'hF : (pin || hib) ? 4'h7 : 4'h4;
    chk(32'(g & m), 32'(e & m));
  endtask : chk_pad
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    er = slv;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  // expected drive {o, oe_n, pu, pd} of pad p
  function automatic logic [3:0] mdl(input int p);
    logic oe, o;
    if (hib || !pin) return 4'h4;
    if (slp) return cfg[p][8] ? {2'h1, cfg[p][9], !cfg[p][9]} : 4'h5;
    case (p * 16 + (cfg[p] & 15))
      0: {oe, o} = po[1:0];
      7: {oe, o} = {1'b1, po[2]};
      16: {oe, o} = po[4:3];
      19: {oe, o} = {1'b1, po[5]};
      22: {oe, o} = po[7:6];
      23: {oe, o} = po[9:8];
      default: {oe, o} = 2'h0;
    endcase
    if (cfg[p][4]) oe = 1'b0;
    return {o, !oe, cfg[p][8] & cfg[p][9], cfg[p][8] & !cfg[p][9]};
  endfunction : mdl
  // expected routed inputs from the resolved pad levels
  function automatic logic [6:0] pex(input logic la, input logic lb);
    logic [6:0] e;
    e = '0;
    case (cfg[0] & 15) 0: e[6] = la; 6: e[5] = la; 12: e[4] = la; default: ; endcase
    case (cfg[1] & 15) 0: e[3] = lb; 6: e[2] = lb; 7: e[1] = lb; 12: e[0] = lb; default: ; endcase
    return e;
  endfunction : pex
  // ==========
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'(adc), 32'h0);
    chk_pad(ds, 4'h8);
    chk_pad(da, 4'h4);
    chk_pad(db, 4'h4);
    apb(1'b0, pfs_pkg::PAD_B_CFG_ADDR, '0);
    chk(rd, 32'h0);
    apb(1'b0, pfs_pkg::PAD_AUX_ADDR, '0);
    chk(rd, 32'h2);
    @(posedge clk);
    boot <= 1'b1;
    @(posedge clk);
    boot <= 1'b0;
    apb(1'b0, pfs_pkg::PAD_AUX_ADDR, '0);
    chk(rd, 32'h6);
    apb(1'b0, 32'h4402_E0D0, '0);
    chk({31'h0, er}, 32'h1);
    for (int k = 0; k < 48; k++) begin
      v = $random(seed);
      msk = k < 24 ? 'h300 : 'h310;
      cfg[0] = ml[k % 6] | (v[9:0] & msk);
      cfg[1] = ml[(k / 4) % 6] | (v[19:10] & msk);
      if (k % 4 == 1) cfg[1] = (cfg[1] & 'h1F) | 'h100;
      aux = 4 | (v[20] << 1) | cfg[0][4];
      @(posedge clk);
      slp <= k % 4 == 1;
      hib <= k % 4 == 2;
      pin <= k % 4 != 3;
      po  <= v[30:21];
      xe  <= k % 4 == 0 ? 2'h3 : {v[31], v[0]};
      xv  <= v[12:11];
      apb(1'b1, pfs_pkg::PAD_AUX_ADDR, aux & 6);
      apb(1'b1, pfs_pkg::PAD_A_CFG_ADDR, cfg[0]);
      apb(1'b1, pfs_pkg::PAD_B_CFG_ADDR, cfg[1]);
      apb(1'b1, pfs_pkg::PAD_AUX_ADDR, aux);
      apb(1'b0, pfs_pkg::PAD_A_CFG_ADDR, '0);
      chk(rd, cfg[0]);
      apb(1'b0, pfs_pkg::PAD_STATUS_ADDR, '0);
      chk(rd & 32'h1C, 32'({!pin, hib, slp, 2'h0}));
      repeat (6) @(posedge clk);
      @(negedge clk);
      ea = mdl(0);
      eb = mdl(1);
      chk_pad(da, ea);
      chk_pad(db, eb);
      chk_pad(ds, hib ? 4'h5 : {aux[1], 3'h0});
      chk(32'(adc), aux & 1);
      if (k % 4 == 0) chk(32'(pi), 32'(pex(ea[2] ? xv[0] : ea[3], eb[2] ? xv[1] : eb[3])));
      // settled pad levels as seen through the status register
      if (k % 4 == 0) begin
        apb(1'b0, pfs_pkg::PAD_STATUS_ADDR, '0);
        chk(rd & 32'h3, 32'({eb[2] ? xv[1] : eb[3], ea[2] ? xv[0] : ea[3]}));
      end
    end
    give_verdict();
  end
  // ==========
  // watchdog against a hung transfer
  initial begin
    repeat (10000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule : pfs_top_test
